/* data_memory_space_decoder_test.sv */
`timescale 1ns/1ps
`default_nettype none
module data_memory_space_decoder_test;
   import dmd_pkg::*;
   logic        clk_i = 0, rst_i = 1, req_i = 0, we_i = 0, spm_req_i = 0;
   logic [2:0]  mode_i = 0;
   logic [1:0]  ptr_sel_i = 0;
   logic [15:0] direct_i = 0, lpm_byte_addr_i = 0;
   logic [5:0]  disp_i = 0, io_addr_i = 0;
   logic [7:0]  wdata_i = 0, io_rdata_i, rd_addr = 0;
   logic [10:0] pc_i = 0;
   logic        ack_o, io_sel_o, xio_sel_o, io_we_o, unmapped_o;
   logic        pmem_byte_hi_o, spm_ok_o;
   logic [7:0]  rdata_o, io_addr_o, io_wdata_o;
   logic [10:0] pmem_word_addr_o;
   logic [15:0] ptr_x_o, ptr_y_o, ptr_z_o;
   logic [3:0]  sel_q;
   logic [7:0]  ioa_q, rd_q, wd_q;
   int          fail_count = 0, n_checks = 0;

   always #2.5 clk_i = ~clk_i;

   dmd_decoder #(.VARIANT(0)) dut (
      .clk_i, .rst_i, .req_i, .we_i, .mode_i, .ptr_sel_i, .direct_i,
      .disp_i, .io_addr_i, .wdata_i, .io_rdata_i, .pc_i, .spm_req_i,
      .lpm_byte_addr_i, .ack_o, .rdata_o, .io_sel_o, .xio_sel_o, .io_we_o,
      .io_addr_o, .io_wdata_o, .unmapped_o, .pmem_word_addr_o,
      .pmem_byte_hi_o, .spm_ok_o, .ptr_x_o, .ptr_y_o, .ptr_z_o);

   dmd_io_model io_model (.clk_i(clk_i), .io_we_i(io_we_o),
      .io_addr_i(io_addr_o), .io_wdata_i(io_wdata_o), .rd_addr_i(rd_addr),
      .io_rdata_o(io_rdata_i));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One access; the extra cycles let the registered pointer outputs and I/O writes settle
   task automatic acc(input logic [2:0] m, input logic [1:0] p,
                      input logic [15:0] a, input logic w,
                      input logic [7:0] d, input int lat);
      int n;
      n = 1;
      mode_i = m;
      ptr_sel_i = p;
      direct_i = a;
      disp_i = a[5:0];
      io_addr_i = a[5:0];
      we_i = w;
      wdata_i = d;
      rd_addr = (m == DMD_MODE_IO) ? a[7:0] + 8'h20 : a[7:0];
      req_i = 1;
      @(negedge clk_i);
      req_i = 0;
      while (ack_o !== 1'b1 && n < 8) begin
         @(negedge clk_i);
         n++;
      end
      chk(16'(n), 16'(lat));
      sel_q = {unmapped_o, xio_sel_o, io_sel_o, io_we_o};
      ioa_q = io_addr_o;
      wd_q = io_wdata_o;
      rd_q = rdata_o;
      repeat (2) @(negedge clk_i);
   endtask : acc

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      acc(DMD_MODE_DIRECT, 0, 16'h001F, 1, 8'hA1, 1);
      chk(16'(sel_q), 16'h0);
      acc(DMD_MODE_DIRECT, 0, 16'h0000, 1, 8'h5C, 1);
      acc(DMD_MODE_DIRECT, 0, 16'h001F, 0, 8'h00, 1);
      chk(16'(rd_q), 16'hA1);
   endtask : t_regs

   task automatic t_io();
      acc(DMD_MODE_DIRECT, 0, 16'h0020, 1, 8'h42, 1);
      chk(16'({sel_q, ioa_q}), 16'h320);
      chk(16'(wd_q), 16'h42);
      acc(DMD_MODE_IO, 0, 16'h003F, 1, 8'hC3, 1);
      chk(16'({sel_q, ioa_q}), 16'h35F);
      acc(DMD_MODE_DIRECT, 0, 16'h005F, 0, 8'h00, 1);
      chk(16'({sel_q, rd_q}), 16'h2C3);
      acc(DMD_MODE_IO, 0, 16'h0000, 0, 8'h00, 1);
      chk(16'({sel_q, rd_q}), 16'h242);
   endtask : t_io

   task automatic t_xio();
      acc(DMD_MODE_DIRECT, 0, 16'h0060, 1, 8'h5A, 1);
      chk(16'({sel_q, ioa_q}), 16'h560);
      acc(DMD_MODE_DIRECT, 0, 16'h00FF, 0, 8'h00, 1);
      chk(16'({sel_q, ioa_q}), 16'h4FF);
      chk(16'(rd_q), 16'h00);
      acc(DMD_MODE_DIRECT, 0, 16'h0060, 0, 8'h00, 1);
      chk(16'(rd_q), 16'h5A);
   endtask : t_xio

   task automatic t_sram();
      acc(DMD_MODE_DIRECT, 0, 16'h0100, 1, 8'h11, 2);
      acc(DMD_MODE_DIRECT, 0, 16'h02FF, 1, 8'h22, 2);
      acc(DMD_MODE_DIRECT, 0, 16'h0300, 1, 8'hEE, 1);
      chk(16'(sel_q), 16'h8);
      acc(DMD_MODE_DIRECT, 0, 16'h0100, 0, 8'h00, 2);
      chk(16'(rd_q), 16'h11);
      acc(DMD_MODE_DIRECT, 0, 16'h02FF, 0, 8'h00, 2);
      chk(16'({sel_q, rd_q}), 16'h022);
   endtask : t_sram

   task automatic t_ptr();
      acc(DMD_MODE_DIRECT, 0, 16'h001A, 1, 8'h05, 1);
      acc(DMD_MODE_DIRECT, 0, 16'h001B, 1, 8'h00, 1);
      acc(DMD_MODE_DIRECT, 0, 16'h001C, 1, 8'h00, 1);
      acc(DMD_MODE_DIRECT, 0, 16'h001D, 1, 8'h01, 1);
      acc(DMD_MODE_DIRECT, 0, 16'h001E, 1, 8'h00, 1);
      acc(DMD_MODE_DIRECT, 0, 16'h001F, 1, 8'h02, 1);
      chk(ptr_x_o, 16'h0005);
      chk(ptr_y_o, 16'h0100);
      chk(ptr_z_o, 16'h0200);
      acc(DMD_MODE_POSTINC, DMD_PTR_X, 0, 1, 8'h77, 1);
      chk(ptr_x_o, 16'h0006);
      acc(DMD_MODE_DIRECT, 0, 16'h0005, 0, 8'h00, 1);
      chk(16'(rd_q), 16'h77);
      // Move X into SRAM so the post-increment writeback is seen there
      acc(DMD_MODE_DIRECT, 0, 16'h001B, 1, 8'h01, 1);
      acc(DMD_MODE_POSTINC, DMD_PTR_X, 0, 1, 8'h6D, 2);
      chk(ptr_x_o, 16'h0107);
      // X with displacement falls back to plain indirect
      acc(DMD_MODE_DIRECT, 0, 16'h001A, 1, 8'h06, 1);
      acc(DMD_MODE_DISP, DMD_PTR_X, 16'h003F, 0, 8'h00, 2);
      chk(16'(rd_q), 16'h6D);
      acc(DMD_MODE_DISP, DMD_PTR_Y, 16'h003F, 1, 8'h3C, 2);
      acc(DMD_MODE_DIRECT, 0, 16'h013F, 0, 8'h00, 2);
      chk(16'(rd_q), 16'h3C);
      acc(DMD_MODE_PREDEC, DMD_PTR_Z, 0, 1, 8'h99, 2);
      chk(ptr_z_o, 16'h01FF);
      acc(DMD_MODE_IND, DMD_PTR_Z, 0, 0, 8'h00, 2);
      chk(16'(rd_q), 16'h99);
   endtask : t_ptr

   task automatic t_pmem();
      lpm_byte_addr_i = 16'h0FFF;
      pc_i = 11'h7FF;
      spm_req_i = 1;
      repeat (3) @(negedge clk_i);
      chk(16'(pmem_word_addr_o), 16'h07FF);
      chk(16'(pmem_byte_hi_o), 16'h1);
      chk(16'(spm_ok_o), 16'h1);
      // An 11-bit word counter wraps past the top of program memory
      lpm_byte_addr_i = 16'h1000;
      repeat (2) @(negedge clk_i);
      chk(16'({pmem_byte_hi_o, pmem_word_addr_o}), 16'h0000);
      spm_req_i = 0;
   endtask : t_pmem

   // ----------------------------------------
   // Run control
   // ----------------------------------------
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop

   // The whole sequence needs well under 300 cycles
   initial begin
      #(5 * 5000);
      fail_count++;
      report_and_stop();
   end

   initial begin
      repeat (10) @(negedge clk_i);
      rst_i = 0;
      @(negedge clk_i);
      t_regs();
      t_io();
      t_xio();
      t_sram();
      t_ptr();
      t_pmem();
      report_and_stop();
   end
endmodule : data_memory_space_decoder_test
`default_nettype wire

/* dmd_agen.sv */
`timescale 1ns/1ps
`default_nettype none
// Address generator for the five data addressing modes and short I/O
module dmd_agen
   import dmd_pkg::*;
(
   input  wire logic [2:0]  mode_i,
   input  wire logic [15:0] direct_i,
   input  wire logic [15:0] ptr_i,
   input  wire logic [5:0]  disp_i,
   input  wire logic [5:0]  io_addr_i,
   output logic      [15:0] addr_o,
   output logic      [15:0] ptr_new_o,
   output logic             ptr_wr_o
);
   always_comb begin
      addr_o    = direct_i;
      ptr_new_o = ptr_i;
      ptr_wr_o  = 1'b0;
      case (dmd_mode_e'(mode_i))
         DMD_MODE_DIRECT:  addr_o = direct_i;
         DMD_MODE_IND:     addr_o = ptr_i;
         DMD_MODE_DISP:    addr_o = ptr_i + {10'h000, disp_i};
         DMD_MODE_PREDEC: begin
            addr_o    = ptr_i - 16'h0001;
            ptr_new_o = ptr_i - 16'h0001;
            ptr_wr_o  = 1'b1;
         end
         DMD_MODE_POSTINC: begin
            addr_o    = ptr_i;
            ptr_new_o = ptr_i + 16'h0001;
            ptr_wr_o  = 1'b1;
         end
         DMD_MODE_IO:      addr_o = {10'h000, io_addr_i} + DMD_IO_OFFSET;
         default:          addr_o = direct_i;
      endcase
   end
endmodule : dmd_agen
`default_nettype wire

/* dmd_decoder.sv */
//
// Behaviour
// - 0x0000-0x001F maps to register file
// - 0x0020-0x005F maps to standard I/O
// - 0x0060-0x00FF maps to extended I/O
// - SRAM from 0x0100, 512 or 1024 bytes
// - Short I/O cannot reach extended I/O
// - All regions reachable in every mode except short I/O
// - Displacement up to 63 on Y/Z
// - Pre-decrement before, post-increment after, write back
// - Top six registers form X, Y, Z
// - SRAM access completes in two cycles
// - Program memory 2K/4K/8K sixteen-bit words
// - Program counter 11/12/13 bits wide
// - Smallest variant: self-program store anywhere
// - Program memory load reads whole space
// - Pointers may index working registers
// - Short I/O address plus 0x20 in data
`timescale 1ns/1ps
`default_nettype none
module dmd_decoder
   import dmd_pkg::*;
#(
   parameter int VARIANT = 0,   // 0 smallest, 1 middle, 2 largest
   parameter int PC_W    = (VARIANT == 0) ? DMD_PC_W_SMALL :
                           (VARIANT == 1) ? DMD_PC_W_MID : DMD_PC_W_LARGE,
   parameter int SRAM_N  = (VARIANT == 0) ? DMD_SRAM_BYTES_SMALL
                                          : DMD_SRAM_BYTES_LARGE
)(
   input  wire logic            clk_i,
   input  wire logic            rst_i,
   // Data access request from the core
   input  wire logic            req_i,
   input  wire logic            we_i,
   input  wire logic [2:0]      mode_i,
   input  wire logic [1:0]      ptr_sel_i,
   input  wire logic [15:0]     direct_i,
   input  wire logic [5:0]      disp_i,
   input  wire logic [5:0]      io_addr_i,
   input  wire logic [7:0]      wdata_i,
   // Peripheral I/O read data (standard and extended)
   input  wire logic [7:0]      io_rdata_i,
   // Program memory side
   input  wire logic [PC_W-1:0] pc_i,
   input  wire logic            spm_req_i,
   input  wire logic [15:0]     lpm_byte_addr_i,
   // Outputs
   output logic                 ack_o,
   output logic [7:0]           rdata_o,
   output logic                 io_sel_o,
   output logic                 xio_sel_o,
   output logic                 io_we_o,
   output logic [7:0]           io_addr_o,
   output logic [7:0]           io_wdata_o,
   output logic                 unmapped_o,
   output logic [PC_W-1:0]      pmem_word_addr_o,
   output logic                 pmem_byte_hi_o,
   output logic                 spm_ok_o,
   output logic [15:0]          ptr_x_o,
   output logic [15:0]          ptr_y_o,
   output logic [15:0]          ptr_z_o
);

   //---------------------------------------------------------------
   // Storage
   //---------------------------------------------------------------
   logic [7:0] regfile_q [32];
   logic [7:0] sram_q    [SRAM_N];

   logic [15:0] sram_last;
   assign sram_last = (VARIANT == 0) ? DMD_SRAM_LAST_SMALL
                                     : DMD_SRAM_LAST_LARGE;

   //---------------------------------------------------------------
   // Address generation
   //---------------------------------------------------------------
   logic [15:0] ptr_cur;
   logic [4:0]  ptr_lo;
   logic [15:0] addr;
   logic [15:0] ptr_new;
   logic        ptr_wr;
   logic [4:0]  region;
   logic [2:0]  mode_eff;

   always_comb begin
      case (dmd_ptr_e'(ptr_sel_i))
         DMD_PTR_X: ptr_lo = DMD_PTR_X_LO;
         DMD_PTR_Y: ptr_lo = DMD_PTR_Y_LO;
         default:   ptr_lo = DMD_PTR_Z_LO;
      endcase
      ptr_cur = {regfile_q[ptr_lo + 5'h01], regfile_q[ptr_lo]};
   end

   // Displacement form only uses Y or Z; an X request falls back
   // to plain indirect so no undefined base is added
   always_comb begin
      mode_eff = mode_i;
      if (dmd_mode_e'(mode_i) == DMD_MODE_DISP &&
          dmd_ptr_e'(ptr_sel_i) == DMD_PTR_X)
         mode_eff = DMD_MODE_IND;
   end

   dmd_agen u_agen (
      .mode_i    (mode_eff),
      .direct_i  (direct_i),
      .ptr_i     (ptr_cur),
      .disp_i    (disp_i),
      .io_addr_i (io_addr_i),
      .addr_o    (addr),
      .ptr_new_o (ptr_new),
      .ptr_wr_o  (ptr_wr)
   );

   dmd_region u_region (
      .addr_i      (addr),
      .sram_last_i (sram_last),
      .region_o    (region)
   );

   //---------------------------------------------------------------
   // Access sequencer
   //---------------------------------------------------------------
   dmd_state_e  st_q;
   logic [15:0] addr_q;
   logic        we_q;
   logic [7:0]  wdata_q;

   logic idle;
   assign idle = (st_q == DMD_ST_IDLE);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q    <= DMD_ST_IDLE;
         addr_q  <= 16'h0000;
         we_q    <= 1'b0;
         wdata_q <= 8'h00;
      end else begin
         case (st_q)
            DMD_ST_IDLE: begin
               if (req_i && region == DMD_RG_SRAM) begin
                  st_q    <= DMD_ST_SRAM;
                  addr_q  <= addr;
                  we_q    <= we_i;
                  wdata_q <= wdata_i;
               end
            end
            DMD_ST_SRAM: st_q <= DMD_ST_IDLE;
            default:     st_q <= DMD_ST_IDLE;
         endcase
      end
   end

   // SRAM: request cycle plus one array cycle
   logic [15:0] sram_off;
   assign sram_off = addr_q - DMD_SRAM_FIRST;

   always_ff @(posedge clk_i) begin
      if (st_q == DMD_ST_SRAM && we_q)
         sram_q[sram_off[$clog2(SRAM_N)-1:0]] <= wdata_q;
   end

   // Register file: direct data-space access and pointer write back
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < 32; i++)
            regfile_q[i] <= 8'h00;
      end else if (idle && req_i) begin
         if (we_i && region == DMD_RG_REG)
            regfile_q[addr[4:0]] <= wdata_i;
         if (ptr_wr) begin
            regfile_q[ptr_lo]         <= ptr_new[7:0];
            regfile_q[ptr_lo + 5'h01] <= ptr_new[15:8];
         end
      end
   end

   //---------------------------------------------------------------
   // Answer and I/O strobes
   //---------------------------------------------------------------
   logic is_io_mode;
   assign is_io_mode = (dmd_mode_e'(mode_i) == DMD_MODE_IO);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ack_o      <= 1'b0;
         rdata_o    <= 8'h00;
         io_sel_o   <= 1'b0;
         xio_sel_o  <= 1'b0;
         io_we_o    <= 1'b0;
         io_addr_o  <= 8'h00;
         io_wdata_o <= 8'h00;
         unmapped_o <= 1'b0;
      end else begin
         ack_o      <= 1'b0;
         io_sel_o   <= 1'b0;
         xio_sel_o  <= 1'b0;
         io_we_o    <= 1'b0;
         unmapped_o <= 1'b0;
         if (st_q == DMD_ST_SRAM) begin
            ack_o   <= 1'b1;
            rdata_o <= sram_q[sram_off[$clog2(SRAM_N)-1:0]];
         end else if (idle && req_i) begin
            case (region)
               DMD_RG_REG: begin
                  ack_o   <= 1'b1;
                  rdata_o <= regfile_q[addr[4:0]];
               end
               DMD_RG_IO: begin
                  ack_o      <= 1'b1;
                  io_sel_o   <= 1'b1;
                  io_we_o    <= we_i;
                  io_addr_o  <= addr[7:0];
                  io_wdata_o <= wdata_i;
                  rdata_o    <= io_rdata_i;
               end
               DMD_RG_XIO: begin
                  ack_o      <= 1'b1;
                  xio_sel_o  <= ~is_io_mode;
                  io_we_o    <= we_i & ~is_io_mode;
                  io_addr_o  <= addr[7:0];
                  io_wdata_o <= wdata_i;
                  rdata_o    <= io_rdata_i;
               end
               DMD_RG_SRAM: ;
               default: begin
                  ack_o      <= 1'b1;
                  unmapped_o <= 1'b1;
               end
            endcase
         end
      end
   end

   //---------------------------------------------------------------
   // Program memory side
   //---------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pmem_word_addr_o <= '0;
         pmem_byte_hi_o   <= 1'b0;
         spm_ok_o         <= 1'b0;
      end else begin
         pmem_word_addr_o <= lpm_byte_addr_i[PC_W:1];
         pmem_byte_hi_o   <= lpm_byte_addr_i[0];
         // No boot split on smallest variant; larger parts refuse
         // the store here while pc_i is all ones
         spm_ok_o <= spm_req_i &&
                     ((VARIANT == 0) || (pc_i != '1));
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ptr_x_o <= 16'h0000;
         ptr_y_o <= 16'h0000;
         ptr_z_o <= 16'h0000;
      end else begin
         ptr_x_o <= {regfile_q[DMD_PTR_X_LO + 5'h01], regfile_q[DMD_PTR_X_LO]};
         ptr_y_o <= {regfile_q[DMD_PTR_Y_LO + 5'h01], regfile_q[DMD_PTR_Y_LO]};
         ptr_z_o <= {regfile_q[DMD_PTR_Z_LO + 5'h01], regfile_q[DMD_PTR_Z_LO]};
      end
   end

   //---------------------------------------------------------------
   // Checks
   //---------------------------------------------------------------
   property p_sram_two;
      @(posedge clk_i) disable iff (rst_i)
      (idle && req_i && region == DMD_RG_SRAM) |-> ##2 ack_o;
   endproperty
   a_sram_two: assert property (p_sram_two)
      else $error("sram answer not two cycles");

   property p_reg_range;
      @(posedge clk_i) disable iff (rst_i)
      (addr <= 16'h001F) |-> region == DMD_RG_REG;
   endproperty
   a_reg_range: assert property (p_reg_range)
      else $error("register range misdecoded");

   property p_io_range;
      @(posedge clk_i) disable iff (rst_i)
      (addr >= 16'h0020 && addr <= 16'h005F) |-> region == DMD_RG_IO;
   endproperty
   a_io_range: assert property (p_io_range)
      else $error("io range misdecoded");

   property p_xio_range;
      @(posedge clk_i) disable iff (rst_i)
      (addr >= 16'h0060 && addr <= 16'h00FF) |-> region == DMD_RG_XIO;
   endproperty
   a_xio_range: assert property (p_xio_range)
      else $error("extended io misdecoded");

   property p_unmapped;
      @(posedge clk_i) disable iff (rst_i)
      (idle && req_i && addr > sram_last) |=> unmapped_o && ack_o;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped address not flagged");

   property p_short_io;
      @(posedge clk_i) disable iff (rst_i)
      (idle && req_i && is_io_mode) |=> !xio_sel_o && io_sel_o;
   endproperty
   a_short_io: assert property (p_short_io)
      else $error("short io reached wrong block");

   property p_postinc;
      @(posedge clk_i) disable iff (rst_i)
      (idle && req_i && dmd_mode_e'(mode_i) == DMD_MODE_POSTINC
       && ptr_sel_i == 2'h0 && region != DMD_RG_REG)
      |=> ##1 ptr_x_o == $past(ptr_cur, 2) + 16'h0001;
   endproperty
   a_postinc: assert property (p_postinc)
      else $error("post increment not written back");

   property p_disp;
      @(posedge clk_i) disable iff (rst_i)
      (dmd_mode_e'(mode_i) == DMD_MODE_DISP && ptr_sel_i != 2'h0)
      |-> addr == ptr_cur + {10'h000, disp_i};
   endproperty
   a_disp: assert property (p_disp)
      else $error("displacement address wrong");

   c_sram:  cover property (@(posedge clk_i) disable iff (rst_i)
                            idle && req_i && region == DMD_RG_SRAM);
   c_xio:   cover property (@(posedge clk_i) xio_sel_o);
   c_unmap: cover property (@(posedge clk_i) unmapped_o);
endmodule : dmd_decoder
`default_nettype wire

/* dmd_io_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Peripheral register bank standing behind the decoder's I/O side
module dmd_io_model (
   input  wire logic       clk_i,
   input  wire logic       io_we_i,
   input  wire logic [7:0] io_addr_i,
   input  wire logic [7:0] io_wdata_i,
   input  wire logic [7:0] rd_addr_i,
   output logic      [7:0] io_rdata_o
);
   logic [7:0] mem_q [256];

   // Unwritten places answer the inverted index, never a fixed level
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem_q[i] = ~i[7:0];
      end
   end

   always @(posedge clk_i) begin
      if (io_we_i) begin
         mem_q[io_addr_i] <= io_wdata_i;
      end
   end

   // Read data follows the address of the request being made
   assign io_rdata_o = mem_q[rd_addr_i];
endmodule : dmd_io_model
`default_nettype wire

/* dmd_pkg.sv */
package dmd_pkg;
   // Data space regions
   localparam logic [15:0] DMD_REG_FIRST  = 16'h0000;
   localparam logic [15:0] DMD_REG_LAST   = 16'h001F;
   localparam logic [15:0] DMD_IO_FIRST   = 16'h0020;
   localparam logic [15:0] DMD_IO_LAST    = 16'h005F;
   localparam logic [15:0] DMD_XIO_FIRST  = 16'h0060;
   localparam logic [15:0] DMD_XIO_LAST   = 16'h00FF;
   localparam logic [15:0] DMD_SRAM_FIRST = 16'h0100;
   localparam logic [15:0] DMD_SRAM_LAST_SMALL = 16'h02FF;
   localparam logic [15:0] DMD_SRAM_LAST_LARGE = 16'h04FF;
   localparam int          DMD_SRAM_BYTES_SMALL = 512;
   localparam int          DMD_SRAM_BYTES_LARGE = 1024;
   // Short I/O instruction offset into data space
   localparam logic [15:0] DMD_IO_OFFSET  = 16'h0020;
   localparam logic [5:0]  DMD_IO_ADDR_MAX = 6'h3F;
   // Displacement is six bits unsigned, at most 63
   localparam int          DMD_DISP_W     = 6;
   // Pointer pairs: low byte register index
   localparam logic [4:0]  DMD_PTR_X_LO   = 5'h1A;
   localparam logic [4:0]  DMD_PTR_Y_LO   = 5'h1C;
   localparam logic [4:0]  DMD_PTR_Z_LO   = 5'h1E;
   // Program memory per variant: words and counter width
   localparam int          DMD_PC_W_SMALL = 11;
   localparam int          DMD_PC_W_MID   = 12;
   localparam int          DMD_PC_W_LARGE = 13;
   // Access cycles for SRAM
   localparam int          DMD_SRAM_CYCLES = 2;

   typedef enum logic [2:0] {
      DMD_MODE_DIRECT = 3'h0,
      DMD_MODE_IND    = 3'h1,
      DMD_MODE_DISP   = 3'h2,
      DMD_MODE_PREDEC = 3'h3,
      DMD_MODE_POSTINC= 3'h4,
      DMD_MODE_IO     = 3'h5
   } dmd_mode_e;

   typedef enum logic [1:0] {
      DMD_PTR_X = 2'h0,
      DMD_PTR_Y = 2'h1,
      DMD_PTR_Z = 2'h2
   } dmd_ptr_e;

   typedef enum logic [4:0] {
      DMD_RG_REG  = 5'b00001,
      DMD_RG_IO   = 5'b00010,
      DMD_RG_XIO  = 5'b00100,
      DMD_RG_SRAM = 5'b01000,
      DMD_RG_NONE = 5'b10000
   } dmd_region_e;

   typedef enum logic [2:0] {
      DMD_ST_IDLE = 3'b001,
      DMD_ST_SRAM = 3'b010,
      DMD_ST_DONE = 3'b100
   } dmd_state_e;
endpackage : dmd_pkg

/* dmd_region.sv */
`timescale 1ns/1ps
`default_nettype none
// Classifies one data address into its region
module dmd_region
   import dmd_pkg::*;
(
   input  wire logic [15:0] addr_i,
   input  wire logic [15:0] sram_last_i,
   output logic      [4:0]  region_o
);
   always_comb begin
      if (addr_i <= DMD_REG_LAST)
         region_o = DMD_RG_REG;
      else if (addr_i <= DMD_IO_LAST)
         region_o = DMD_RG_IO;
      else if (addr_i <= DMD_XIO_LAST)
         region_o = DMD_RG_XIO;
      else if (addr_i <= sram_last_i)
         region_o = DMD_RG_SRAM;
      else
         region_o = DMD_RG_NONE;
   end
endmodule : dmd_region
`default_nettype wire
